// ===== rtl/fesw_regs.vh
// Notes on behaviour
// - Power-on reset clears the write-enable bit; no write starts until software sets it.
// - Data EEPROM writes are blocked while the 72 ms power-up timer runs.
// - A write starts only with write-enable set and unlock immediately before the trigger.
// - The unlock port stores nothing; writes only advance the unlock detector.
// - Instruction slots after an EEPROM write, erase or long write starts are discarded; short writes discard none; software fills them with no-ops.
// - After each long write all four 14-bit buffer words reset to 3FFF.
// - With data code protection, internal EEPROM access works; external access is refused.
// - With data code protection, external program memory writes are refused too.
// - With program code protection, internal use works; external access to it is refused.
// - Self-writes into regions chosen by the write-protect bits are suppressed.
`ifndef FESW_REGS_VH
`define FESW_REGS_VH
// Register indices; byte address is four times the index
`define FESW_IDX_FLAGS    9'h00D
`define FESW_IDX_ENABLES  9'h08D
`define FESW_IDX_DATA_LO  9'h10C
`define FESW_IDX_ADDR_LO  9'h10D
`define FESW_IDX_DATA_HI  9'h10E
`define FESW_IDX_ADDR_HI  9'h10F
`define FESW_IDX_CTRL     9'h18C
`define FESW_IDX_UNLOCK   9'h18D
`define FESW_IDX_CONFIG   9'h1F0
// Control one fields
`define FESW_CTL_PGM      7
`define FESW_CTL_ERASE    4
`define FESW_CTL_WERR     3
`define FESW_CTL_WRITE_ENABLE_BIT     2
`define FESW_CTL_WR       1
`define FESW_CTL_RD       0
// Flag and enable fields
`define FESW_IRQ_DONE     4
`define FESW_ENA_MASK     8'hD0
// Config fields
`define FESW_CFG_CP_DATA  2
`define FESW_CFG_CP_PGM   3
`define FESW_CFG_RESET    4'h3
// Unlock keys
`define FESW_KEY_FIRST    8'h55
`define FESW_KEY_SECOND   8'hAA
// Write-protect region limits (protected below the limit)
`define FESW_WP_LIM_10    13'h0100
`define FESW_WP_LIM_01    13'h0800
`define FESW_WP_LIM_00    13'h1000
// Buffer word value after a long write
`define FESW_BUF_BLANK    14'h3FFF
// Timing
`define FESW_CLK_KHZ      25000
`define FESW_PWRT_MS      72
`define FESW_WRITE_MS     2
`define FESW_PWRT_CYC     (`FESW_PWRT_MS * `FESW_CLK_KHZ)
`define FESW_WRITE_CYC    (`FESW_WRITE_MS * `FESW_CLK_KHZ)
`define FESW_DISCARD_CYC  2
// AXI responses
`define FESW_RESP_OKAY    2'h0
`define FESW_RESP_SLVERR  2'h2
`endif

// ===== rtl/fesw_ctrl.v
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`include "fesw_regs.vh"
module fesw_ctrl #(
    parameter PWRT_CYCLES  = `FESW_PWRT_CYC,
    parameter WRITE_CYCLES = `FESW_WRITE_CYC,
    parameter CNT_W        = 21
) (
    // Clock and resets
    input  wire        clk_sys_in,
    input  wire        resetn_in,
    input  wire        core_reset_in,
    // AXI4-Lite slave
    input  wire [11:0] s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output wire        s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output wire        s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [11:0] s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output wire        s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    // Core slot control and interrupt
    output wire        core_discard_out,
    output wire        core_stall_out,
    output wire        irq_out,
    // Nonvolatile array side
    output reg         mem_pgm_wr_out,
    output reg         mem_erase_out,
    output reg         mem_ee_wr_out,
    output reg         mem_rd_out,
    output reg         mem_sel_pgm_out,
    output reg  [12:0] mem_addr_out,
    output reg  [55:0] mem_wdata_out,
    input  wire [13:0] mem_rdata_in,
    // External programmer pins
    input  wire        ext_req_in,
    input  wire        ext_write_in,
    input  wire        ext_target_ee_in,
    output reg         ext_grant_out
);
// ----------------------------------------
// Declarations
// ----------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_SLOT = 3'b010;
localparam ST_BUSY = 3'b100;
localparam UL_IDLE = 3'b001;
localparam UL_HALF = 3'b010;
localparam UL_ARM  = 3'b100;

reg  [7:0]       data_lo_ff;
reg  [5:0]       data_hi_ff;
reg  [7:0]       addr_lo_ff;
reg  [4:0]       addr_hi_ff;
reg              pgm_sel_ff;
reg              erase_ff;
reg              werr_ff;
reg              write_enable_bit_ff;
reg              wr_ff;
reg              rd_ff;
reg              done_flag_ff;
reg  [7:0]       ena_ff;
reg  [3:0]       cfg_ff;
reg  [2:0]       ul_ff;
reg  [2:0]       st_ff;
reg              op_pgm_ff;
reg              op_long_ff;
reg  [13:0]      buf_ff [0:3];
reg  [CNT_W-1:0] pwrt_ff;
reg  [CNT_W-1:0] tmr_ff;
reg  [2:0]       ext_s1_ff;
reg  [2:0]       ext_s2_ff;
reg  [2:0]       nxt_ul;
reg              prot;
reg  [31:0]      rd_mux;
reg              rd_hit;
integer          i;

wire        wr_take  = s_axi_awvalid_in & s_axi_wvalid_in & ~s_axi_bvalid_out;
wire        wr_en    = wr_take & s_axi_wstrb_in[0];
wire [8:0]  wr_idx   = s_axi_awaddr_in[10:2];
wire [7:0]  wd       = s_axi_wdata_in[7:0];
wire        rd_take  = s_axi_arvalid_in & ~s_axi_rvalid_out;
wire [8:0]  rd_idx   = s_axi_araddr_in[10:2];
wire        ctl_wr   = wr_en & (wr_idx == `FESW_IDX_CTRL);
wire        flag_rd  = rd_take & (rd_idx == `FESW_IDX_FLAGS);
wire        pwrt_run = (pwrt_ff != PWRT_CYCLES[CNT_W-1:0]);
wire [12:0] pgm_addr = {addr_hi_ff, addr_lo_ff};
wire [13:0] word_new = {data_hi_ff, data_lo_ff};
wire        trig     = ctl_wr & wd[`FESW_CTL_WR] & st_ff[0] & ~wr_ff
                       & write_enable_bit_ff & wd[`FESW_CTL_WRITE_ENABLE_BIT] & ul_ff[2];
wire        is_ee    = trig & ~pgm_sel_ff;
wire        is_erase = trig & pgm_sel_ff & erase_ff;
wire        is_long  = trig & pgm_sel_ff & ~erase_ff & (addr_lo_ff[1:0] == 2'b11);
wire        is_short = trig & pgm_sel_ff & ~erase_ff & (addr_lo_ff[1:0] != 2'b11);
wire        launch   = (is_ee & ~pwrt_run) | ((is_erase | is_long) & ~prot);
wire        rd_go    = ctl_wr & wd[`FESW_CTL_RD] & st_ff[0];
wire        finish   = st_ff[2] & (tmr_ff == WRITE_CYCLES[CNT_W-1:0]);

// ----------------------------------------
// Bus handshakes and core outputs
// ----------------------------------------
assign s_axi_awready_out = wr_take;
assign s_axi_wready_out  = wr_take;
assign s_axi_arready_out = ~s_axi_rvalid_out;
assign core_discard_out  = st_ff[1];
assign core_stall_out    = st_ff[2] & op_pgm_ff;
assign irq_out           = done_flag_ff & ena_ff[`FESW_IRQ_DONE];

// ----------------------------------------
// Write-protect region check
// ----------------------------------------
always @* begin
    case (cfg_ff[1:0])
        2'b10:   prot = (pgm_addr < `FESW_WP_LIM_10);
        2'b01:   prot = (pgm_addr < `FESW_WP_LIM_01);
        2'b00:   prot = (pgm_addr < `FESW_WP_LIM_00);
        default: prot = 1'b0;
    endcase
    prot = prot & pgm_sel_ff;
end

// ----------------------------------------
// Unlock detector, no storage behind the port
// ----------------------------------------
always @* begin
    nxt_ul = ul_ff;
    if (wr_en) begin
        if (wr_idx == `FESW_IDX_UNLOCK) begin
            if (wd == `FESW_KEY_FIRST)
                nxt_ul = UL_HALF;
            else if ((wd == `FESW_KEY_SECOND) && ul_ff[1])
                nxt_ul = UL_ARM;
            else
                nxt_ul = UL_IDLE;
        end else begin
            nxt_ul = UL_IDLE;
        end
    end
end

// ----------------------------------------
// Read multiplexer
// ----------------------------------------
always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_idx)
        `FESW_IDX_FLAGS:   rd_mux[`FESW_IRQ_DONE] = done_flag_ff;
        `FESW_IDX_ENABLES: rd_mux[7:0] = ena_ff;
        `FESW_IDX_DATA_LO: rd_mux[7:0] = data_lo_ff;
        `FESW_IDX_ADDR_LO: rd_mux[7:0] = addr_lo_ff;
        `FESW_IDX_DATA_HI: rd_mux[5:0] = data_hi_ff;
        `FESW_IDX_ADDR_HI: rd_mux[4:0] = addr_hi_ff;
        `FESW_IDX_CTRL:    rd_mux[7:0] = {pgm_sel_ff, 2'b00, erase_ff, werr_ff, write_enable_bit_ff, wr_ff, rd_ff};
        `FESW_IDX_UNLOCK:  rd_mux[7:0] = 8'h00;
        `FESW_IDX_CONFIG:  rd_mux[3:0] = cfg_ff;
        default:           rd_hit = 1'b0;
    endcase
end

// ----------------------------------------
// Bus responses
// ----------------------------------------
always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_bresp_out  <= `FESW_RESP_OKAY;
        s_axi_rvalid_out <= 1'b0;
        s_axi_rresp_out  <= `FESW_RESP_OKAY;
        s_axi_rdata_out  <= 32'h0000_0000;
    end else begin
        if (wr_take) begin
            s_axi_bvalid_out <= 1'b1;
            case (wr_idx)
                `FESW_IDX_FLAGS, `FESW_IDX_ENABLES, `FESW_IDX_DATA_LO, `FESW_IDX_ADDR_LO,
                `FESW_IDX_DATA_HI, `FESW_IDX_ADDR_HI, `FESW_IDX_CTRL, `FESW_IDX_UNLOCK,
                `FESW_IDX_CONFIG: s_axi_bresp_out <= `FESW_RESP_OKAY;
                default:          s_axi_bresp_out <= `FESW_RESP_SLVERR;
            endcase
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
        if (rd_take) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= rd_mux;
            s_axi_rresp_out  <= rd_hit ? `FESW_RESP_OKAY : `FESW_RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end
end

// ----------------------------------------
// Power-up timer and external access gate
// ----------------------------------------
always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
        pwrt_ff       <= {CNT_W{1'b0}};
        ext_s1_ff     <= 3'b000;
        ext_s2_ff     <= 3'b000;
        ext_grant_out <= 1'b0;
    end else begin
        if (pwrt_run)
            pwrt_ff <= pwrt_ff + 1'b1;
        ext_s1_ff <= {ext_req_in, ext_write_in, ext_target_ee_in};
        ext_s2_ff <= ext_s1_ff;
        // Programmer sees nothing while code protection holds the target
        if (ext_s2_ff[0])
            ext_grant_out <= ext_s2_ff[2] & ~cfg_ff[`FESW_CFG_CP_DATA];
        else
            ext_grant_out <= ext_s2_ff[2] & ~cfg_ff[`FESW_CFG_CP_PGM]
                             & ~(ext_s2_ff[1] & cfg_ff[`FESW_CFG_CP_DATA]);
    end
end

// ----------------------------------------
// Registers, sequencer and array strobes
// ----------------------------------------
always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
        data_lo_ff   <= 8'h00;
        data_hi_ff   <= 6'h00;
        addr_lo_ff   <= 8'h00;
        addr_hi_ff   <= 5'h00;
        pgm_sel_ff   <= 1'b0;
        erase_ff     <= 1'b0;
        werr_ff      <= 1'b0;
        write_enable_bit_ff      <= 1'b0;
        wr_ff        <= 1'b0;
        rd_ff        <= 1'b0;
        done_flag_ff <= 1'b0;
        ena_ff       <= 8'h00;
        cfg_ff       <= `FESW_CFG_RESET;
        ul_ff        <= UL_IDLE;
        st_ff        <= ST_IDLE;
        op_pgm_ff    <= 1'b0;
        op_long_ff   <= 1'b0;
        tmr_ff       <= {CNT_W{1'b0}};
        mem_pgm_wr_out  <= 1'b0;
        mem_erase_out   <= 1'b0;
        mem_ee_wr_out   <= 1'b0;
        mem_rd_out      <= 1'b0;
        mem_sel_pgm_out <= 1'b0;
        mem_addr_out    <= 13'h0000;
        mem_wdata_out   <= 56'h00_0000_0000_0000;
        for (i = 0; i < 4; i = i + 1)
            buf_ff[i] <= `FESW_BUF_BLANK;
    end else if (core_reset_in) begin
        // Abort without power loss: error bit set if a write was under way, cleared if idle; sequencer drops
        werr_ff    <= ~st_ff[0];
        write_enable_bit_ff    <= 1'b0;
        wr_ff      <= 1'b0;
        rd_ff      <= 1'b0;
        ul_ff      <= UL_IDLE;
        st_ff      <= ST_IDLE;
        done_flag_ff   <= 1'b0;
        ena_ff         <= 8'h00;
        mem_pgm_wr_out <= 1'b0;
        mem_erase_out  <= 1'b0;
        mem_ee_wr_out  <= 1'b0;
        mem_rd_out     <= 1'b0;
    end else begin
        ul_ff          <= nxt_ul;
        mem_pgm_wr_out <= 1'b0;
        mem_erase_out  <= 1'b0;
        mem_ee_wr_out  <= 1'b0;
        mem_rd_out     <= 1'b0;
        if (wr_en) begin
            case (wr_idx)
                `FESW_IDX_ENABLES: ena_ff <= wd & `FESW_ENA_MASK;
                `FESW_IDX_DATA_LO: data_lo_ff <= wd;
                `FESW_IDX_ADDR_LO: addr_lo_ff <= wd;
                `FESW_IDX_DATA_HI: data_hi_ff <= wd[5:0];
                `FESW_IDX_ADDR_HI: addr_hi_ff <= wd[4:0];
                `FESW_IDX_CONFIG:  cfg_ff <= wd[3:0];
                `FESW_IDX_CTRL: begin
                    pgm_sel_ff <= wd[`FESW_CTL_PGM];
                    erase_ff   <= wd[`FESW_CTL_ERASE];
                    werr_ff    <= wd[`FESW_CTL_WERR];
                    write_enable_bit_ff    <= wd[`FESW_CTL_WRITE_ENABLE_BIT];
                end
                default: ;
            endcase
        end
        // Flag: read clears, write loads bit 4, completion sets and wins
        if (finish)
            done_flag_ff <= 1'b1;
        else if (flag_rd)
            done_flag_ff <= 1'b0;
        else if (wr_en && (wr_idx == `FESW_IDX_FLAGS))
            done_flag_ff <= wd[`FESW_IRQ_DONE];
        // Short write: word into buffer, trigger bit drops after one cycle
        wr_ff <= 1'b0;
        if (is_short) begin
            buf_ff[addr_lo_ff[1:0]] <= word_new;
            wr_ff <= 1'b1;
        end
        if (rd_go) begin
            rd_ff           <= 1'b1;
            mem_rd_out      <= 1'b1;
            mem_sel_pgm_out <= pgm_sel_ff;
            mem_addr_out    <= pgm_sel_ff ? pgm_addr : {5'h00, addr_lo_ff};
        end else if (rd_ff) begin
            // Array answers within the strobe cycle; data taken at its end
            rd_ff      <= 1'b0;
            data_lo_ff <= mem_rdata_in[7:0];
            if (mem_sel_pgm_out)
                data_hi_ff <= mem_rdata_in[13:8];
        end
        case (st_ff)
            ST_IDLE: begin
                tmr_ff <= {CNT_W{1'b0}};
                if (launch) begin
                    st_ff           <= ST_SLOT;
                    wr_ff           <= 1'b1;
                    op_pgm_ff       <= pgm_sel_ff;
                    op_long_ff      <= is_long;
                    mem_sel_pgm_out <= pgm_sel_ff;
                    mem_pgm_wr_out  <= is_long;
                    mem_erase_out   <= is_erase;
                    mem_ee_wr_out   <= is_ee;
                    mem_addr_out    <= pgm_sel_ff ? {pgm_addr[12:2], 2'b00} : {5'h00, addr_lo_ff};
                    mem_wdata_out   <= pgm_sel_ff ? {word_new, buf_ff[2], buf_ff[1], buf_ff[0]}
                                                  : {48'h0000_0000_0000, data_lo_ff};
                end
            end
            ST_SLOT: begin
                wr_ff  <= 1'b1;
                tmr_ff <= tmr_ff + 1'b1;
                if (tmr_ff == (`FESW_DISCARD_CYC - 1)) begin
                    st_ff  <= ST_BUSY;
                    tmr_ff <= {CNT_W{1'b0}};
                end
            end
            ST_BUSY: begin
                tmr_ff <= tmr_ff + 1'b1;
                wr_ff  <= ~finish;
                if (finish) begin
                    st_ff <= ST_IDLE;
                    if (op_long_ff)
                        for (i = 0; i < 4; i = i + 1)
                            buf_ff[i] <= `FESW_BUF_BLANK;
                end
            end
            default: st_ff <= ST_IDLE;
        endcase
    end
end

endmodule // fesw_ctrl

// ===== testbench/fesw_ctrl_assertions.sv
`timescale 1ns/10ps
module fesw_ctrl_assertions #(
    parameter PWRT_CYCLES  = 20,
    parameter WRITE_CYCLES = 10
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire resetn_in,
    // Bus
    input wire s_axi_awready_out,
    input wire s_axi_wready_out,
    input wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire s_axi_arvalid_in,
    input wire s_axi_arready_out,
    input wire s_axi_rvalid_out,
    input wire s_axi_rready_in,
    // Core and array
    input wire core_discard_out,
    input wire core_stall_out,
    input wire irq_out,
    input wire mem_pgm_wr_out,
    input wire mem_erase_out,
    input wire mem_ee_wr_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    int pwr_cnt;
    int stall_cnt;
    // Helper counts: cycles since power-on, length of the current stall
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pwr_cnt   <= 0;
            stall_cnt <= 0;
        end else begin
            if (pwr_cnt < PWRT_CYCLES) pwr_cnt <= pwr_cnt + 1;
            stall_cnt <= core_stall_out ? stall_cnt + 1 : 0;
        end
    end
    aw_w_pair_a: assert property (s_axi_awready_out == s_axi_wready_out) else $error("aw and w ready differ");
    write_answer_a: assert property (s_axi_awready_out |=> s_axi_bvalid_out) else $error("no write response");
    b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out) else $error("bvalid dropped");
    read_answer_a: assert property (s_axi_arvalid_in && !s_axi_rvalid_out |-> s_axi_arready_out ##1 s_axi_rvalid_out)
        else $error("read not answered");
    r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out) else $error("rvalid dropped");
    pwrt_block_a: assert property (mem_ee_wr_out |-> pwr_cnt >= PWRT_CYCLES) else $error("early eeprom write");
    discard_len_a: assert property ($rose(core_discard_out) |=> core_discard_out ##1 !core_discard_out)
        else $error("discard length wrong");
    stall_len_a: assert property (core_stall_out |-> stall_cnt <= WRITE_CYCLES) else $error("stall too long");
    pgm_stall_a: assert property (mem_pgm_wr_out |-> ##[0:3] core_stall_out) else $error("no stall on write");
    ee_no_stall_a: assert property (mem_ee_wr_out |=> !core_stall_out[*3]) else $error("stall on eeprom write");
    cover property (mem_pgm_wr_out);
    cover property (mem_erase_out);
    cover property (mem_ee_wr_out);
    cover property ($rose(irq_out));
endmodule // fesw_ctrl_assertions
bind fesw_ctrl fesw_ctrl_assertions #(.PWRT_CYCLES(PWRT_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .core_discard_out(core_discard_out),
    .core_stall_out(core_stall_out), .irq_out(irq_out), .mem_pgm_wr_out(mem_pgm_wr_out),
    .mem_erase_out(mem_erase_out), .mem_ee_wr_out(mem_ee_wr_out));

// ===== testbench/fesw_nvm_model.sv
`timescale 1ns/10ps
module fesw_nvm_model (
    // Array strobes
    input  wire        clk_sys_in,
    input  wire        mem_pgm_wr_in,
    input  wire        mem_erase_in,
    input  wire        mem_ee_wr_in,
    input  wire        mem_rd_in,
    input  wire        mem_sel_pgm_in,
    input  wire [12:0] mem_addr_in,
    input  wire [55:0] mem_wdata_in,
    // Read data
    output wire [13:0] mem_rdata_out
);
    reg [13:0] pgm [0:8191];
    reg [7:0]  ee  [0:255];
    reg [13:0] idle_ff;
    integer    i;
    initial begin
        idle_ff = 14'h0000;
        for (i = 0; i < 8192; i = i + 1)
            pgm[i] = 14'h3FFF;
    end
    // Data valid within the strobe cycle; otherwise toggling lines so stale data never matches
    assign mem_rdata_out = mem_rd_in ? (mem_sel_pgm_in ? pgm[mem_addr_in] : {6'h00, ee[mem_addr_in[7:0]]}) : idle_ff;
    always @(posedge clk_sys_in) begin
        idle_ff <= ~idle_ff;
        if (mem_pgm_wr_in)
            for (i = 0; i < 4; i = i + 1)
                pgm[mem_addr_in + i] <= mem_wdata_in[i*14 +: 14];
        if (mem_erase_in)
            for (i = 0; i < 32; i = i + 1)
                pgm[{mem_addr_in[12:5], 5'h00} + i] <= 14'h3FFF;
        if (mem_ee_wr_in)
            ee[mem_addr_in[7:0]] <= mem_wdata_in[7:0];
    end
endmodule // fesw_nvm_model

// ===== testbench/test_flash_eeprom_self_write_ctrl.sv
`timescale 1ns/10ps
`include "fesw_regs.vh"
module test_flash_eeprom_self_write_ctrl;
    localparam PW = 20;
    localparam WC = 10;
    localparam [6:0] TD = 7'b0011100, TP = 7'b1100000, TE = 7'b1000110, TW = 7'b0010001;
    reg         clk = 0, rstn = 0, crst = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, xr = 0, xw = 0, xe = 0;
    reg  [11:0] awa = 12'h000, ara = 12'h000;
    reg  [31:0] wd = 32'h00000000, v;
    wire        awr, wrr, bv, arr, rv, disc, stl, irq, pw, er, ew, rd, sp, gnt;
    wire [1:0]  br, rr;
    wire [31:0] rdt;
    wire [12:0] ma;
    wire [55:0] mw;
    wire [13:0] mr;
    int         fail_count = 0, n_checks = 0, ee_n = 0, pg_n = 0, er_n = 0, st_n = 0, k, i;
    reg  [13:0] w [0:3];
    fesw_ctrl #(.PWRT_CYCLES(PW), .WRITE_CYCLES(WC)) DUT (
        .clk_sys_in(clk), .resetn_in(rstn), .core_reset_in(crst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdt),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .core_discard_out(disc),
        .core_stall_out(stl), .irq_out(irq), .mem_pgm_wr_out(pw), .mem_erase_out(er), .mem_ee_wr_out(ew),
        .mem_rd_out(rd), .mem_sel_pgm_out(sp), .mem_addr_out(ma), .mem_wdata_out(mw), .mem_rdata_in(mr),
        .ext_req_in(xr), .ext_write_in(xw), .ext_target_ee_in(xe), .ext_grant_out(gnt));
    fesw_nvm_model u_nvm (.clk_sys_in(clk), .mem_pgm_wr_in(pw), .mem_erase_in(er), .mem_ee_wr_in(ew), .mem_rd_in(rd),
        .mem_sel_pgm_in(sp), .mem_addr_in(ma), .mem_wdata_in(mw), .mem_rdata_out(mr));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        ee_n <= ee_n + ew;
        pg_n <= pg_n + pw;
        er_n <= er_n + er;
        st_n <= st_n + stl;
    end
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input [31:0] got, input [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input [8:0] idx, input [7:0] d, input [1:0] e = `FESW_RESP_OKAY);
        int t = 0;
        @(posedge clk);
        awa <= {1'b0, idx, 2'b00};
        wd <= {24'h000000, d};
        awv <= 1;
        wv <= 1;
        bre <= 1;
        do @(posedge clk); while (awr !== 1'b1 && ++t < 99);
        awv <= 0;
        wv <= 0;
        do @(posedge clk); while (bv !== 1'b1 && ++t < 99);
        chk(br, e);
        bre <= 0;
    endtask
    task automatic rdr(input [8:0] idx, input [1:0] e = `FESW_RESP_OKAY);
        int t = 0;
        @(posedge clk);
        ara <= {1'b0, idx, 2'b00};
        arv <= 1;
        rre <= 1;
        do @(posedge clk); while (arr !== 1'b1 && ++t < 99);
        arv <= 0;
        do @(posedge clk); while (rv !== 1'b1 && ++t < 99);
        v = rdt;
        chk(rr, e);
        rre <= 0;
    endtask
    task automatic go(input [7:0] c);
        wr(`FESW_IDX_UNLOCK, `FESW_KEY_FIRST);
        wr(`FESW_IDX_UNLOCK, `FESW_KEY_SECOND);
        wr(`FESW_IDX_CTRL, c);
    endtask
    task automatic pw_word(input [12:0] a, input [13:0] d);
        wr(`FESW_IDX_ADDR_HI, {3'h0, a[12:8]});
        wr(`FESW_IDX_ADDR_LO, a[7:0]);
        wr(`FESW_IDX_DATA_LO, d[7:0]);
        wr(`FESW_IDX_DATA_HI, {2'h0, d[13:8]});
        go(8'h86);
    endtask
    task automatic wirq;
        int t = 0;
        while (irq !== 1'b1 && t < 200) begin
            @(posedge clk);
            t++;
        end
        chk(irq, 1);
        rdr(`FESW_IDX_FLAGS);
    endtask
    function automatic bit eg(input bit d, input bit p, input bit e, input bit x);
        return !(e ? d : (p | (x & d)));
    endfunction
    task wrap_up;
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(92137));
        repeat (3) @(posedge clk);
        rstn <= 1;
        wr(`FESW_IDX_CTRL, 8'h04);
        go(8'h06);
        repeat (3) @(posedge clk);
        chk(ee_n, 0);
        rstn <= 0;
        repeat (2) @(posedge clk);
        rstn <= 1;
        rdr(`FESW_IDX_CTRL);
        chk(v[2:0], 0);
        rdr(`FESW_IDX_FLAGS);
        chk(v, 0);
        rdr(`FESW_IDX_CONFIG);
        chk(v, `FESW_CFG_RESET);
        rdr(9'h1FF, `FESW_RESP_SLVERR);
        chk(v, 0);
        wr(9'h1FF, 8'h5A, `FESW_RESP_SLVERR);
        wr(`FESW_IDX_ENABLES, 8'hFF);
        rdr(`FESW_IDX_ENABLES);
        chk(v, `FESW_ENA_MASK);
        repeat (PW) @(posedge clk);
        k = $urandom;
        wr(`FESW_IDX_ADDR_LO, k[7:0]);
        wr(`FESW_IDX_DATA_LO, k[15:8]);
        wr(`FESW_IDX_CTRL, 8'h04);
        go(8'h06);
        wirq();
        chk(ee_n, 1);
        chk(u_nvm.ee[k[7:0]], k[15:8]);
        chk(st_n, 0);
        wr(`FESW_IDX_FLAGS, 8'h10);
        wr(`FESW_IDX_ENABLES, 8'h00);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        wr(`FESW_IDX_ENABLES, 8'h10);
        repeat (2) @(posedge clk);
        wirq();
        rdr(`FESW_IDX_FLAGS);
        chk(v[4], 0);
        for (k = 0; k < 5; k++) begin
            wr(`FESW_IDX_CTRL, k == 4 ? 8'h00 : 8'h04);
            if (k == 1 || k == 3 || k == 4) wr(`FESW_IDX_UNLOCK, `FESW_KEY_FIRST);
            if (k == 1) wr(`FESW_IDX_ADDR_LO, 8'h00);
            if (k >= 1 && k != 3) wr(`FESW_IDX_UNLOCK, `FESW_KEY_SECOND);
            if (k == 2) wr(`FESW_IDX_UNLOCK, `FESW_KEY_FIRST);
            rdr(`FESW_IDX_UNLOCK);
            chk(v, 0);
            wr(`FESW_IDX_CTRL, 8'h06);
            repeat (4) @(posedge clk);
            chk(ee_n, 1);
        end
        wr(`FESW_IDX_CONFIG, 8'h0F);
        wr(`FESW_IDX_CTRL, 8'h84);
        for (i = 0; i < 4; i++) begin
            w[i] = $urandom;
            k = st_n;
            chk(pg_n, 0);
            pw_word(13'h100 + i, w[i]);
        end
        wirq();
        chk(pg_n, 1);
        chk(st_n - k, WC + 1);
        for (i = 0; i < 4; i++)
            chk(u_nvm.pgm[13'h100 + i], w[i]);
        pw_word(13'h107, w[0]);
        wirq();
        for (i = 0; i < 4; i++)
            chk(u_nvm.pgm[13'h104 + i], i == 3 ? w[0] : `FESW_BUF_BLANK);
        wr(`FESW_IDX_ADDR_LO, 8'h01);
        wr(`FESW_IDX_CTRL, 8'h81);
        rdr(`FESW_IDX_DATA_LO);
        chk(v, w[1][7:0]);
        rdr(`FESW_IDX_DATA_HI);
        chk(v, w[1][13:8]);
        wr(`FESW_IDX_CONFIG, 8'h0E);
        wr(`FESW_IDX_CTRL, 8'h84);
        pw_word(13'h0FF, w[2]);
        repeat (WC + 5) @(posedge clk);
        chk(pg_n, 2);
        chk(u_nvm.pgm[13'h0FF], `FESW_BUF_BLANK);
        pw_word(13'h103, w[3]);
        wirq();
        chk(pg_n, 3);
        wr(`FESW_IDX_CTRL, 8'h94);
        go(8'h96);
        wirq();
        chk(er_n, 1);
        chk(u_nvm.pgm[13'h103], `FESW_BUF_BLANK);
        wr(`FESW_IDX_CTRL, 8'h80);
        wr(`FESW_IDX_CONFIG, 8'h03);
        wr(`FESW_IDX_CTRL, 8'h84);
        pw_word(13'h10B, w[1]);
        repeat (3) @(posedge clk);
        crst <= 1;
        @(posedge clk);
        crst <= 0;
        rdr(`FESW_IDX_CTRL);
        chk(v[3:2], 2'b10);
        crst <= 1;
        @(posedge clk);
        crst <= 0;
        rdr(`FESW_IDX_CTRL);
        chk(v[3], 0);
        for (k = 0; k < 7; k++) begin
            wr(`FESW_IDX_CONFIG, {4'h0, TP[k], TD[k], 2'b11});
            xe <= TE[k];
            xw <= TW[k];
            xr <= 1;
            repeat (6) @(posedge clk);
            chk(gnt, eg(TD[k], TP[k], TE[k], TW[k]));
            xr <= 0;
            repeat (5) @(posedge clk);
            chk(gnt, 0);
        end
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
endmodule // test_flash_eeprom_self_write_ctrl
